// [src/uvr_consts.svh]
// constants for the undervoltage reset and flag block
// assumes: included by the top module and by the bench
`ifndef UVR_CONSTS_SVH
`define UVR_CONSTS_SVH

// register offsets on the plain register port
`define UVR_OFS_THR 3'h0
`define UVR_OFS_WID 3'h1
`define UVR_OFS_FLG 3'h2
`define UVR_OFS_PRG 3'h3
`define UVR_OFS_STS 3'h4

// reset values
`define UVR_THR_POR 8'h66
`define UVR_WID_POR 2'h1

// valid trip level codes
`define UVR_CODE_1V70 8'h66
`define UVR_CODE_1V90 8'h55
`define UVR_CODE_2V55 8'h33
`define UVR_CODE_3V15 8'h99
`define UVR_CODE_3V80 8'haa

// flag bit positions
`define UVR_FLG_UV 2
`define UVR_FLG_THR 1
`define UVR_FLG_WDC 0

// key that resets the whole chip
`define UVR_PRG_KEY 8'h55

// low-width limits in low-speed periods
`define UVR_LIM_0 8'h08
`define UVR_LIM_1 8'h20
`define UVR_LIM_2 8'h40
`define UVR_LIM_3 8'h80

// soft reset delay in low-speed periods
`define UVR_SOFT_DELAY 16

`endif

// [src/uvr_pkg.sv]
// types for the undervoltage reset and flag block
// assumes: uvr_consts.svh sits beside this file
package uvr_pkg;

  // operating mode, gray coded
  typedef enum logic [1:0] {
    uvr_mode_fast = 2'h0,
    uvr_mode_slow = 2'h1,
    uvr_mode_idle = 2'h3,
    uvr_mode_sleep = 2'h2
  } uvr_mode_type;

  // what a full reset asks of the rest of the chip
  typedef struct packed {
    logic pc_zero;
    logic int_off;
    logic wdt_tb_clear;
    logic timers_off;
    logic io_inputs;
    logic sp_top;
  } uvr_actions_type;

  // status register flags
  typedef struct packed {
    logic powerdown_flag;
    logic watchdog_timeout_flag;
  } uvr_status_type;

endpackage

// [src/uvr_top.sv]
// undervoltage reset, threshold check and reset cause flags
// assumes: one clock, lso_tick one clk pulse per low-speed period,
// comparator and watchdog inputs synchronous to clk
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "uvr_consts.svh"

module uvr_top
  import uvr_pkg::*;
#(
  parameter int SOFT_DELAY = `UVR_SOFT_DELAY
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // analog side and low-speed oscillator
  input wire logic lso_tick,
  input wire logic vdd_low,
  output logic [7:0] trip_level_code,
  // watchdog and mode
  input wire uvr_mode_type mode,
  input wire logic wdt_timeout,
  input wire logic wdt_ctrl_bad,
  // reset outputs
  output logic chip_reset,
  output logic pc_sp_clear,
  output uvr_actions_type reset_actions,
  output uvr_status_type status_flags
);

  localparam logic [7:0] DLY_LAST = 8'(SOFT_DELAY - 1);

  logic [7:0] thr_reg, thr_next;
  logic [1:0] wid_reg, wid_next;
  logic [2:0] flg_reg, flg_next;
  uvr_status_type sts_reg, sts_next;
  logic [7:0] uv_cnt_reg, uv_cnt_next;
  logic [7:0] dly_cnt_reg, dly_cnt_next;
  logic dly_run_reg, dly_run_next;
  logic rst_reg, rst_next;
  logic pcs_reg, pcs_next;
  logic [7:0] rdata_reg, rdata_next;

  logic run_mode;
  logic thr_valid;
  logic [7:0] uv_limit;
  logic uv_fire;
  logic dly_done;
  logic prg_hit;
  logic wdt_run;
  logic wdt_low;

  function automatic logic code_ok(input logic [7:0] c);
    case (c)
      `UVR_CODE_1V70,
      `UVR_CODE_1V90,
      `UVR_CODE_2V55,
      `UVR_CODE_3V15,
      `UVR_CODE_3V80: code_ok = 1'b1;
      default: code_ok = 1'b0;
    endcase
  endfunction

  // event decode
  always_comb begin
    run_mode = (mode == uvr_mode_fast) || (mode == uvr_mode_slow);
    thr_valid = code_ok(thr_reg);
    case (wid_reg)
      2'h0: uv_limit = `UVR_LIM_0;
      2'h1: uv_limit = `UVR_LIM_1;
      2'h2: uv_limit = `UVR_LIM_2;
      default: uv_limit = `UVR_LIM_3;
    endcase
    // first tick lands mid-period, hence n-1..n periods
    uv_fire = run_mode && vdd_low && lso_tick &&
              (uv_cnt_reg == uv_limit - 8'h01);
    dly_done = dly_run_reg && lso_tick && (dly_cnt_reg == DLY_LAST) &&
               (!thr_valid || wdt_ctrl_bad);
    prg_hit = reg_wr && (reg_addr == `UVR_OFS_PRG) &&
              (reg_wdata == `UVR_PRG_KEY);
    wdt_run = wdt_timeout && run_mode;
    wdt_low = wdt_timeout && !run_mode;
  end

  // undervoltage width filter
  always_comb begin
    uv_cnt_next = uv_cnt_reg;
    if (!run_mode || !vdd_low || uv_fire) begin
      uv_cnt_next = 8'h00;
    end else if (lso_tick) begin
      uv_cnt_next = uv_cnt_reg + 8'h01;
    end
  end

  // soft reset delay, shared by both register faults
  always_comb begin
    dly_run_next = dly_run_reg;
    dly_cnt_next = dly_cnt_reg;
    if (dly_done || (dly_run_reg && thr_valid && !wdt_ctrl_bad)) begin
      // fault gone before the end: no stale reset on a later tick
      dly_run_next = 1'b0;
      dly_cnt_next = 8'h00;
    end else if (dly_run_reg) begin
      if (lso_tick) begin
        dly_cnt_next = dly_cnt_reg + 8'h01;
      end
    end else if (!thr_valid || wdt_ctrl_bad) begin
      dly_run_next = 1'b1;
      dly_cnt_next = 8'h00;
    end
  end

  // registers seen by software
  always_comb begin
    thr_next = thr_reg;
    wid_next = wid_reg;
    flg_next = flg_reg;
    sts_next = sts_reg;
    if (reg_wr && reg_addr == `UVR_OFS_THR) begin
      thr_next = reg_wdata;
    end
    if (reg_wr && reg_addr == `UVR_OFS_WID) begin
      wid_next = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == `UVR_OFS_FLG) begin
      flg_next = flg_reg & reg_wdata[2:0];
    end
    // undervoltage reset leaves thr and status alone
    if (dly_done && !thr_valid) begin
      thr_next = `UVR_THR_POR;
    end
    // sets placed after the clear so a same-cycle event wins
    if (uv_fire) begin
      flg_next[`UVR_FLG_UV] = 1'b1;
    end
    if (!thr_valid) begin
      flg_next[`UVR_FLG_THR] = 1'b1;
    end
    if (dly_done && wdt_ctrl_bad) begin
      flg_next[`UVR_FLG_WDC] = 1'b1;
    end
    if (wdt_run) begin
      sts_next.watchdog_timeout_flag = 1'b1;
    end
    if (wdt_low) begin
      sts_next.watchdog_timeout_flag = 1'b1;
      sts_next.powerdown_flag = 1'b1;
    end
  end

  // reset requests
  always_comb begin
    rst_next = uv_fire || dly_done || prg_hit || wdt_run;
    pcs_next = wdt_low;
  end

  // read data, one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `UVR_OFS_THR: rdata_next = thr_reg;
        `UVR_OFS_WID: rdata_next = {6'h00, wid_reg};
        `UVR_OFS_FLG: rdata_next = {5'h00, flg_reg};
        `UVR_OFS_STS: rdata_next = {6'h00, sts_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      thr_reg <= `UVR_THR_POR;
      wid_reg <= `UVR_WID_POR;
      // undervoltage flag is unknown at power-on; zero chosen
      flg_reg <= 3'h0;
      sts_reg <= '0;
      uv_cnt_reg <= 8'h00;
      dly_cnt_reg <= 8'h00;
      dly_run_reg <= 1'b0;
      rst_reg <= 1'b1;
      pcs_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      thr_reg <= thr_next;
      wid_reg <= wid_next;
      flg_reg <= flg_next;
      sts_reg <= sts_next;
      uv_cnt_reg <= uv_cnt_next;
      dly_cnt_reg <= dly_cnt_next;
      dly_run_reg <= dly_run_next;
      rst_reg <= rst_next;
      pcs_reg <= pcs_next;
      rdata_reg <= rdata_next;
    end
  end

  assign trip_level_code = thr_reg;
  assign chip_reset = rst_reg;
  assign pc_sp_clear = pcs_reg || rst_reg;
  assign reset_actions = {6{rst_reg}};
  assign status_flags = sts_reg;
  assign reg_rdata = rdata_reg;

  // checks
  property p_thr_write;
    @(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `UVR_OFS_THR && !dly_done
    |=> trip_level_code == $past(reg_wdata);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("threshold write not taken");

  property p_bad_restore;
    @(posedge clk) disable iff (reset)
    dly_done && !thr_valid
    |=> chip_reset && thr_reg == `UVR_THR_POR;
  endproperty
  a_bad_restore: assert property (p_bad_restore)
    else $error("bad code not restored with reset");

  property p_uv_keep;
    @(posedge clk) disable iff (reset)
    uv_fire && thr_valid && !reg_wr |=> $stable(thr_reg);
  endproperty
  a_uv_keep: assert property (p_uv_keep)
    else $error("threshold changed by undervoltage reset");

  property p_uv_width;
    @(posedge clk) disable iff (reset)
    uv_fire |-> run_mode && vdd_low && uv_cnt_reg + 8'h01 ==
      (wid_reg == 2'h0 ? `UVR_LIM_0 : wid_reg == 2'h1 ? `UVR_LIM_1 :
      wid_reg == 2'h2 ? `UVR_LIM_2 : `UVR_LIM_3);
  endproperty
  a_uv_width: assert property (p_uv_width)
    else $error("undervoltage fired early");

  property p_wid_por;
    @(posedge clk) disable iff (reset)
    $fell(reset) |-> wid_reg == `UVR_WID_POR;
  endproperty
  a_wid_por: assert property (p_wid_por)
    else $error("width select reset value wrong");

  property p_wid_read;
    @(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `UVR_OFS_WID
    |=> reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] == $past(wid_reg);
  endproperty
  a_wid_read: assert property (p_wid_read)
    else $error("width read wrong");

  property p_uv_flag;
    @(posedge clk) disable iff (reset)
    uv_fire |=> chip_reset && flg_reg[`UVR_FLG_UV];
  endproperty
  a_uv_flag: assert property (p_uv_flag)
    else $error("undervoltage flag or reset missing");

  property p_thr_flag;
    @(posedge clk) disable iff (reset)
    !thr_valid |=> flg_reg[`UVR_FLG_THR];
  endproperty
  a_thr_flag: assert property (p_thr_flag)
    else $error("threshold fault flag missing");

  property p_prg_key;
    @(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `UVR_OFS_PRG &&
    reg_wdata == `UVR_PRG_KEY |=> chip_reset;
  endproperty
  a_prg_key: assert property (p_prg_key)
    else $error("key write did not reset");

  property p_wdt_run;
    @(posedge clk) disable iff (reset)
    wdt_run |=> chip_reset && status_flags.watchdog_timeout_flag;
  endproperty
  a_wdt_run: assert property (p_wdt_run)
    else $error("run watchdog timeout handled wrong");

  property p_wdt_low;
    @(posedge clk) disable iff (reset)
    wdt_low && !uv_fire && !dly_done && !prg_hit
    |=> pc_sp_clear && !chip_reset && status_flags == 2'h3;
  endproperty
  a_wdt_low: assert property (p_wdt_low)
    else $error("sleep watchdog timeout handled wrong");

  property p_flg_read;
    @(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `UVR_OFS_FLG |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_flg_read: assert property (p_flg_read)
    else $error("flag upper bits not zero");

  property p_uv_off;
    @(posedge clk) disable iff (reset)
    !run_mode |=> uv_cnt_reg == 8'h00;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("undervoltage counting while halted");

  c_uv_fire: cover property (@(posedge clk) disable iff (reset) uv_fire);
  c_soft_reset: cover property (@(posedge clk) disable iff (reset)
    dly_done && !thr_valid);
  c_prg_reset: cover property (@(posedge clk) disable iff (reset) prg_hit);
  c_wdt_low: cover property (@(posedge clk) disable iff (reset) wdt_low);

endmodule

`default_nettype wire

// [dv/tb.sv]
// self-checking bench for uvr_top
// assumes: uvr_pkg compiled first, uvr_consts.svh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "uvr_consts.svh"

module tb;
  import uvr_pkg::*;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, lso_tick = 0;
  logic vdd_low = 0, wdt_timeout = 0, wdt_ctrl_bad = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, trip_level_code, d, c;
  uvr_mode_type mode = uvr_mode_fast;
  logic chip_reset, pc_sp_clear;
  uvr_actions_type reset_actions;
  uvr_status_type status_flags;
  int n_mismatch = 0, samples_checked = 0, n_rst = 0, n_pcsp = 0;
  int cycles = 0, base, pbase;
  logic [7:0] codes [5] = '{`UVR_CODE_1V90, `UVR_CODE_2V55,
    `UVR_CODE_3V15, `UVR_CODE_1V70, `UVR_CODE_3V80};

  uvr_top #(.SOFT_DELAY(2)) i_uvr_top (
    .clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lso_tick(lso_tick), .vdd_low(vdd_low),
    .trip_level_code(trip_level_code), .mode(mode),
    .wdt_timeout(wdt_timeout), .wdt_ctrl_bad(wdt_ctrl_bad),
    .chip_reset(chip_reset), .pc_sp_clear(pc_sp_clear),
    .reset_actions(reset_actions), .status_flags(status_flags));

  initial forever #2.5 clk = ~clk;

  // pulse counters; the ceiling sits well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (!reset && chip_reset === 1'b1) n_rst++;
    if (!reset && pc_sp_clear === 1'b1 && chip_reset === 1'b0) n_pcsp++;
    if (!reset && reset_actions !== {6{chip_reset}}) begin
      n_mismatch++;
      $display("[FAIL] reset_actions exp %h seen %h", {6{chip_reset}},
        reset_actions);
    end
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  function automatic logic [7:0] lim(input logic [1:0] w);
    return 8'h08 << (w == 2'h0 ? 0 : w + 1);
  endfunction

  function automatic bit valid(input logic [7:0] v);
    return v == `UVR_CODE_1V70 || v == `UVR_CODE_1V90 ||
      v == `UVR_CODE_2V55 || v == `UVR_CODE_3V15 || v == `UVR_CODE_3V80;
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      lso_tick <= 1;
      @(posedge clk);
      lso_tick <= 0;
    end
    repeat (3) @(posedge clk);
  endtask

  // low supply for exactly n ticks, then back up
  task automatic low(input int n);
    @(posedge clk);
    vdd_low <= 1;
    ticks(n);
    vdd_low <= 0;
    @(posedge clk);
  endtask

  task automatic chkr(input string n, input int e);
    chk(n, e[7:0], 8'(n_rst - base));
    base = n_rst;
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hd04b5ace));
    repeat (16) @(posedge clk);
    reset <= 0;
    #1 chk("reset chip_reset", 8'h01, {7'h0, chip_reset});
    // the reset-time pulse is counted at the first edge; start after it
    repeat (2) @(posedge clk);
    base = n_rst;
    rd(`UVR_OFS_THR); chk("thr por", 8'h66, d);
    chk("trip por", 8'h66, trip_level_code);
    rd(`UVR_OFS_WID); chk("wid por", 8'h01, d);
    rd(`UVR_OFS_FLG); chk("flg por", 8'h00, d);
    chk("sts por", 8'h00, {6'h0, status_flags});
    rd(3'h7); chk("unmapped", 8'h00, d);
    wr(3'h7, 8'hff); rd(`UVR_OFS_PRG); chk("prg rd", 8'h00, d);
    done("reset");
    repeat (4) begin
      c = 8'($urandom);
      wr(`UVR_OFS_WID, c); rd(`UVR_OFS_WID);
      chk("wid mask", {6'h0, c[1:0]}, d);
    end
    done("width");
    foreach (codes[i]) begin
      c = codes[i];
      wr(`UVR_OFS_THR, c); rd(`UVR_OFS_THR);
      chk("thr rw", c, d);
      chk("trip", c, trip_level_code);
    end
    ticks(3); rd(`UVR_OFS_FLG); chk("no fault", 8'h00, d);
    chkr("valid codes", 0);
    done("codes");
    for (int w = 0; w < 4; w++) begin
      wr(`UVR_OFS_WID, 8'(w));
      low(lim(w) - 1); chkr("short low", 0);
      low(lim(w)); chkr("long low", 1);
      rd(`UVR_OFS_FLG); chk("uv flag", 8'h04, d);
      rd(`UVR_OFS_THR); chk("thr kept", `UVR_CODE_3V80, d);
      wr(`UVR_OFS_FLG, 8'hfb); rd(`UVR_OFS_FLG);
      chk("uv clr", 8'h00, d);
    end
    @(posedge clk) mode <= uvr_mode_idle;
    wr(`UVR_OFS_WID, 8'h00); low(12); chkr("idle low", 0);
    mode <= uvr_mode_slow;
    low(8); chkr("slow low", 1);
    wr(`UVR_OFS_FLG, 8'h00);
    done("undervoltage");
    do c = 8'($urandom); while (valid(c));
    wr(`UVR_OFS_THR, c); rd(`UVR_OFS_FLG);
    chk("thr fault", 8'h02, d);
    chkr("before delay", 0);
    ticks(2); chkr("soft reset", 1);
    rd(`UVR_OFS_THR); chk("thr restore", 8'h66, d);
    wr(`UVR_OFS_FLG, 8'h00); rd(`UVR_OFS_FLG); chk("fault clr", 8'h00, d);
    @(posedge clk) wdt_ctrl_bad <= 1;
    ticks(3);
    wdt_ctrl_bad <= 0;
    chkr("wdc reset", 1);
    rd(`UVR_OFS_FLG); chk("wdc flag", 8'h01, d);
    done("faults");
    repeat (3) begin
      do c = 8'($urandom); while (c == `UVR_PRG_KEY);
      wr(`UVR_OFS_PRG, c);
    end
    chkr("prg other", 0);
    wr(`UVR_OFS_PRG, `UVR_PRG_KEY);
    // let the pulse counter see the reset before reading it
    repeat (2) @(posedge clk);
    chkr("prg key", 1);
    done("prog");
    mode <= uvr_mode_fast;
    @(posedge clk) wdt_timeout <= 1;
    @(posedge clk) wdt_timeout <= 0;
    repeat (2) @(posedge clk);
    chkr("wdt run", 1);
    chk("sts run", 8'h01, {6'h0, status_flags});
    pbase = n_pcsp;
    mode <= uvr_mode_sleep;
    @(posedge clk) wdt_timeout <= 1;
    @(posedge clk) wdt_timeout <= 0;
    repeat (2) @(posedge clk);
    chkr("wdt sleep", 0);
    chk("pc sp clr", 8'h01, 8'(n_pcsp - pbase));
    chk("sts sleep", 8'h03, {6'h0, status_flags});
    rd(`UVR_OFS_FLG); chk("flg kept", 8'h01, d);
    done("watchdog");
    print_verdict();
  end
endmodule
`default_nettype wire
